/* rtl/aci_pkg.sv */
package aci_pkg;
    // -----------------------------------------------------------------
    // Sizes and fixed addresses
    // -----------------------------------------------------------------
    localparam int WORD_W = 48;
    localparam int ADDR_W = 15;
    localparam int PC_W = 15;
    localparam int NSRC = 4;
    localparam int NCOND = 16;
    localparam logic [ADDR_W-1:0] CLOCK_ADDR = 15'h0000;
    localparam logic [ADDR_W-1:0] INTR_ADDR = 15'h0007;
    localparam logic [2:0] SCAN_CLOCK_POS = 3'h0;
    localparam logic [2:0] SCAN_INTR_POS = 3'h1;
    localparam logic [2:0] SCAN_LAST_POS = 3'h7;
    // Upper address field lies in word bits 38..24
    localparam int UPPER_ADDR_LSB = 24;
    localparam int LOWER_INSTR_W = 24;
    localparam logic [WORD_W-1:0] CLOCK_INCR = 48'h0000_0000_0001;

    // -----------------------------------------------------------------
    // Carriers
    // -----------------------------------------------------------------
    typedef struct packed {
        logic req;
        logic we;
        logic [ADDR_W-1:0] addr;
        logic [WORD_W-1:0] wdata;
    } aci_mem_req_t;

    typedef struct packed {
        logic sel;      // function-select strobe
        logic setClk;   // set clock enable
        logic clrClk;   // clear clock enable
        logic [3:0] cond;  // condition index
        logic enIntr;   // enable interrupt on cond
        logic disIntr;  // disable interrupt on cond
    } aci_fsel_t;

    typedef enum logic [2:0] {
        ST_IDLE, ST_CLK_RD, ST_CLK_WR, ST_CLK_RESTORE, ST_INT_REF, ST_INT_EXIT
    } aci_state_t;
endpackage : aci_pkg

/* rtl/aci_src_combine.sv */
`timescale 1ns/10ps
`default_nettype none
module aci_src_combine (
    input wire logic [aci_pkg::NSRC-1:0] cableIntr, // Cable group lines
    input wire logic [aci_pkg::NCOND-1:0] condRaw, // Internal conditions
    input wire logic [aci_pkg::NCOND-1:0] condSel, // Program selections
    output logic intrAny // Combined line
);
    import aci_pkg::*;
    logic [NCOND-1:0] gated;
    // Only selected internal conditions may interrupt
    genvar gi;
    generate
        for (gi = 0; gi < NCOND; gi++) begin : g_sel
            assign gated[gi] = condRaw[gi] & condSel[gi];
        end
    endgenerate
    // One line, no identity kept
    assign intrAny = (|cableIntr) | (|gated);
endmodule : aci_src_combine
`default_nettype wire

/* rtl/aci_aux_service.sv */
`timescale 1ns/10ps
`default_nettype none
module aci_aux_service (
    input wire logic sys_clk, // 10 MHz clock
    input wire logic nrst, // Sync reset, low
    input wire logic mainsTick, // One-cycle pulse per mains cycle
    input wire aci_pkg::aci_fsel_t fsel, // Function-select command
    input wire logic [aci_pkg::NSRC-1:0] cableIntr, // Cable interrupts
    input wire logic [aci_pkg::NCOND-1:0] condRaw, // Fault/buffer conditions
    input wire logic seqExit, // Sequence exit
    input wire logic stDone, // Search/transfer done
    input wire logic cpuStopped, // Computer stopped
    input wire logic svcDone, // Interrupt routine finished
    input wire logic memAck, // Storage reference done
    input wire logic [aci_pkg::WORD_W-1:0] memRdata, // Storage read data
    input wire logic [aci_pkg::WORD_W-1:0] accIn, // Accumulator now
    input wire logic [aci_pkg::PC_W-1:0] pcIn, // Program counter now
    input wire logic halfFlagIn, // instruction_half_flag
    output aci_pkg::aci_mem_req_t memReq_r, // Storage request
    output logic [aci_pkg::WORD_W-1:0] accOut_r, // Accumulator restore value
    output logic accLoad_r, // Load accumulator pulse
    output logic [aci_pkg::PC_W-1:0] pcOut_r, // New program counter
    output logic pcLoad_r, // Load PC pulse
    output logic [aci_pkg::LOWER_INSTR_W-1:0] irOut_r, // Lower instruction
    output logic irLoad_r, // Load instruction register pulse
    output logic halfExit_r, // Half exit pulse
    output logic auxBusy_r, // Main program held
    output logic clockEnable_r, // clock_enable_flop
    output logic tickPending_r, // tick_pending_flop
    output logic intrBlock_r, // interrupt_block_flop
    output logic savedHalf_r, // saved_half_flag_flop
    output logic [2:0] scanPos_r // Scanner position
);
    import aci_pkg::*;

    // -----------------------------------------------------------------
    // Source combining
    // -----------------------------------------------------------------
    typedef struct packed {
        aci_state_t st;
        logic [2:0] scan;
        logic clkEn;
        logic tick;
        logic blk;
        logic saved;
        logic [NCOND-1:0] sel;
        logic [WORD_W-1:0] auxAcc;
        aci_mem_req_t mem;
        logic [WORD_W-1:0] accOut;
        logic accLoad;
        logic [PC_W-1:0] pcOut;
        logic pcLoad;
        logic [LOWER_INSTR_W-1:0] ir;
        logic irLoad;
        logic halfExit;
        logic busy;
    } aci_regs_t;

    aci_regs_t q_r, q_nxt;
    logic intrAny;
    logic startOk;

    aci_src_combine u_comb (
        .cableIntr(cableIntr),
        .condRaw(condRaw),
        .condSel(q_r.sel),
        .intrAny(intrAny)
    );

    // Only at an exit, an ST completion, or while stopped
    assign startOk = seqExit | stDone | cpuStopped;

    // -----------------------------------------------------------------
    // Next state
    // -----------------------------------------------------------------
    always_comb begin
        q_nxt = q_r;
        q_nxt.accLoad = 1'b0;
        q_nxt.pcLoad = 1'b0;
        q_nxt.irLoad = 1'b0;
        q_nxt.halfExit = 1'b0;
        // Function select: clock enable and interrupt selection
        if (fsel.sel) begin
            if (fsel.setClk) begin
                q_nxt.clkEn = 1'b1;
            end else if (fsel.clrClk) begin
                q_nxt.clkEn = 1'b0;
            end
            if (fsel.enIntr) begin
                q_nxt.sel[fsel.cond] = 1'b1;
            end else if (fsel.disIntr) begin
                q_nxt.sel[fsel.cond] = 1'b0;
            end
        end
        // Routine end releases the block; a new entry below wins
        if (svcDone) begin
            q_nxt.blk = 1'b0;
        end
        unique case (q_r.st)
            ST_IDLE: begin
                if (q_r.scan == SCAN_CLOCK_POS && q_r.tick) begin
                    // Scanner holds at 000 until allowed to start
                    if (startOk) begin
                        q_nxt.st = ST_CLK_RD;
                        q_nxt.auxAcc = accIn;
                        q_nxt.mem = '{req: 1'b1, we: 1'b0, addr: CLOCK_ADDR, wdata: '0};
                    end
                end else if (q_r.scan == SCAN_INTR_POS && intrAny && !q_r.blk) begin
                    if (startOk) begin
                        q_nxt.st = ST_INT_REF;
                        q_nxt.mem.req = 1'b1;
                        q_nxt.mem.we = 1'b1;
                        q_nxt.mem.addr = INTR_ADDR;
                        q_nxt.mem.wdata = '0;
                        q_nxt.mem.wdata[UPPER_ADDR_LSB +: PC_W] = pcIn;
                        q_nxt.blk = 1'b1;
                        q_nxt.saved = ~halfFlagIn;
                    end
                end else begin
                    q_nxt.scan = q_r.scan + 3'h1;
                end
            end
            ST_CLK_RD: begin
                if (memAck) begin
                    // Add one and write back
                    q_nxt.mem = '{req: 1'b1, we: 1'b1, addr: CLOCK_ADDR,
                                  wdata: memRdata + CLOCK_INCR};
                    q_nxt.st = ST_CLK_WR;
                end
            end
            ST_CLK_WR: begin
                if (memAck) begin
                    q_nxt.mem.req = 1'b0;
                    q_nxt.st = ST_CLK_RESTORE;
                end
            end
            ST_CLK_RESTORE: begin
                q_nxt.accOut = q_r.auxAcc;
                q_nxt.accLoad = 1'b1;
                q_nxt.tick = 1'b0;
                q_nxt.scan = q_r.scan + 3'h1;
                q_nxt.st = ST_IDLE;
            end
            ST_INT_REF: begin
                // One reference: write PC, take word into IR
                if (memAck) begin
                    q_nxt.mem.req = 1'b0;
                    q_nxt.ir = memRdata[LOWER_INSTR_W-1:0];
                    q_nxt.irLoad = 1'b1;
                    q_nxt.pcOut = INTR_ADDR;
                    q_nxt.pcLoad = 1'b1;
                    q_nxt.st = ST_INT_EXIT;
                end
            end
            ST_INT_EXIT: begin
                q_nxt.halfExit = 1'b1;
                q_nxt.scan = q_r.scan + 3'h1;
                q_nxt.st = ST_IDLE;
            end
            default: begin
                q_nxt.st = ST_IDLE; // Unused codes fall back to idle
            end
        endcase
        // Mains pulse sets pending; it beats the completion clear
        if (mainsTick && q_r.clkEn) begin
            q_nxt.tick = 1'b1;
        end
        // Busy kept as its own flop so the output needs no decode
        q_nxt.busy = (q_nxt.st != ST_IDLE);
    end

    // -----------------------------------------------------------------
    // State register
    // -----------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            q_r <= '0;
        end else begin
            q_r <= q_nxt;
        end
    end

    // -----------------------------------------------------------------
    // Outputs straight from flops
    // -----------------------------------------------------------------
    assign memReq_r = q_r.mem;
    assign accOut_r = q_r.accOut;
    assign accLoad_r = q_r.accLoad;
    assign pcOut_r = q_r.pcOut;
    assign pcLoad_r = q_r.pcLoad;
    assign irOut_r = q_r.ir;
    assign irLoad_r = q_r.irLoad;
    assign halfExit_r = q_r.halfExit;
    assign auxBusy_r = q_r.busy;
    assign clockEnable_r = q_r.clkEn;
    assign tickPending_r = q_r.tick;
    assign intrBlock_r = q_r.blk;
    assign savedHalf_r = q_r.saved;
    assign scanPos_r = q_r.scan;

    // -----------------------------------------------------------------
    // Checks
    // -----------------------------------------------------------------
    AST_NO_TICK_DISABLED: assert property (
        @(posedge sys_clk) disable iff (!nrst)
        (mainsTick && !q_r.clkEn && !q_r.tick) |=> !q_r.tick)
        else $error("tick set while clock disabled");
    AST_TICK_SET: assert property (
        @(posedge sys_clk) disable iff (!nrst)
        (mainsTick && q_r.clkEn) |=> q_r.tick)
        else $error("tick not set on mains pulse");
    AST_CLK_AT_000: assert property (
        @(posedge sys_clk) disable iff (!nrst)
        (q_r.st == ST_IDLE && q_nxt.st == ST_CLK_RD) |-> q_r.scan == SCAN_CLOCK_POS)
        else $error("advance started off position 000");
    AST_CLK_INC: assert property (
        @(posedge sys_clk) disable iff (!nrst)
        (q_r.st == ST_CLK_RD && memAck) |=> q_r.mem.wdata == $past(memRdata) + CLOCK_INCR
        && q_r.mem.we && q_r.mem.addr == CLOCK_ADDR)
        else $error("clock write not old plus one");
    AST_ACC_RESTORE: assert property (
        @(posedge sys_clk) disable iff (!nrst)
        (q_r.st == ST_CLK_RESTORE) |=> accLoad_r && accOut_r == q_r.auxAcc)
        else $error("accumulator not restored");
    AST_TICK_CLR: assert property (
        @(posedge sys_clk) disable iff (!nrst)
        (q_r.st == ST_CLK_RESTORE && !mainsTick) |=> !q_r.tick)
        else $error("tick not cleared at completion");
    AST_INT_POS: assert property (
        @(posedge sys_clk) disable iff (!nrst)
        (q_r.st == ST_IDLE && q_nxt.st == ST_INT_REF) |->
        q_r.scan == SCAN_INTR_POS && intrAny && !q_r.blk && startOk)
        else $error("interrupt entry without cause");
    AST_INT_REF: assert property (
        @(posedge sys_clk) disable iff (!nrst)
        (q_r.st == ST_INT_REF) |-> q_r.mem.addr == INTR_ADDR && q_r.mem.we
        && q_r.blk)
        else $error("interrupt reference wrong");
    AST_INT_PC: assert property (
        @(posedge sys_clk) disable iff (!nrst)
        (q_r.st == ST_INT_REF && memAck) |=> pcLoad_r && pcOut_r == INTR_ADDR
        ##1 halfExit_r)
        else $error("interrupt exit wrong");
    AST_SAVED_INV: assert property (
        @(posedge sys_clk) disable iff (!nrst)
        (q_r.st == ST_IDLE && q_nxt.st == ST_INT_REF) |=> q_r.saved == !$past(halfFlagIn))
        else $error("saved half flag not inverted");
    AST_START_OK: assert property (
        @(posedge sys_clk) disable iff (!nrst)
        (q_r.st == ST_IDLE && q_nxt.st != ST_IDLE) |-> startOk)
        else $error("service started without opening");
    AST_SEL_GATE: assert property (
        @(posedge sys_clk) disable iff (!nrst)
        (cableIntr == '0 && (condRaw & q_r.sel) == '0) |-> !intrAny)
        else $error("unselected condition interrupted");
    // Scanner parking: a pending service holds its position until an opening
    AST_CLK_HOLD: assert property (
        @(posedge sys_clk) disable iff (!nrst)
        (q_r.st == ST_IDLE && q_r.scan == SCAN_CLOCK_POS && q_r.tick && !startOk)
        |=> q_r.scan == SCAN_CLOCK_POS && q_r.st == ST_IDLE)
        else $error("scanner left 000 with advance pending");
    AST_INT_HOLD: assert property (
        @(posedge sys_clk) disable iff (!nrst)
        (q_r.st == ST_IDLE && q_r.scan == SCAN_INTR_POS && intrAny && !q_r.blk && !startOk)
        |=> q_r.scan == SCAN_INTR_POS && q_r.st == ST_IDLE)
        else $error("scanner left interrupt position with line up");
    AST_BLOCK_INHIBIT: assert property (
        @(posedge sys_clk) disable iff (!nrst)
        (q_r.st == ST_IDLE && q_r.blk) |=> q_r.st != ST_INT_REF)
        else $error("interrupt entered while blocked");
    AST_BLK_RELEASE: assert property (
        @(posedge sys_clk) disable iff (!nrst)
        (svcDone && !(q_r.st == ST_IDLE && q_nxt.st == ST_INT_REF)) |=> !q_r.blk)
        else $error("block not released at routine end");
    AST_ONE_REF: assert property (
        @(posedge sys_clk) disable iff (!nrst)
        (q_r.st == ST_INT_REF && memAck) |=> !memReq_r.req)
        else $error("second storage reference on entry");
    AST_PC_STORED: assert property (
        @(posedge sys_clk) disable iff (!nrst)
        (q_r.st == ST_IDLE && q_nxt.st == ST_INT_REF)
        |=> q_r.mem.wdata[UPPER_ADDR_LSB +: PC_W] == $past(pcIn))
        else $error("program counter not in upper address field");
    AST_CLK_READ: assert property (
        @(posedge sys_clk) disable iff (!nrst)
        (q_r.st == ST_IDLE && q_nxt.st == ST_CLK_RD) |=> memReq_r.req && !memReq_r.we
        && memReq_r.addr == CLOCK_ADDR && q_r.auxAcc == $past(accIn))
        else $error("advance did not save accumulator and read clock word");
    AST_WR_DONE: assert property (
        @(posedge sys_clk) disable iff (!nrst)
        (q_r.st == ST_CLK_WR && memAck) |=> !memReq_r.req && q_r.st == ST_CLK_RESTORE)
        else $error("clock write not closed");
    AST_CLK_EN_SET: assert property (
        @(posedge sys_clk) disable iff (!nrst)
        (fsel.sel && fsel.setClk) |=> q_r.clkEn)
        else $error("clock enable not set");
    AST_CLK_EN_CLR: assert property (
        @(posedge sys_clk) disable iff (!nrst)
        (fsel.sel && !fsel.setClk && fsel.clrClk) |=> !q_r.clkEn)
        else $error("clock enable not cleared");
    AST_HALF_EXIT: assert property (
        @(posedge sys_clk) disable iff (!nrst)
        (q_r.st == ST_INT_EXIT) |=> halfExit_r && q_r.st == ST_IDLE)
        else $error("entry did not leave by the half exit");
endmodule : aci_aux_service
`default_nettype wire

/* bench/aci_mem_model.sv */
`timescale 1ns/10ps
`default_nettype none
module aci_mem_model #(
    parameter logic [47:0] INIT0 = 48'h0000_00ff_ffff, // Clock word, carry across a byte
    parameter logic [47:0] INIT7 = 48'h3d00_005a_bcde // Entry word, lower instruction
) (
    input wire logic sys_clk, // Bench clock
    input wire logic nrst, // Sync reset, low
    input wire aci_pkg::aci_mem_req_t memReq, // Storage request
    input wire logic slow, // Answer after five idle cycles
    output logic memAck, // One-cycle done pulse
    output logic [aci_pkg::WORD_W-1:0] memRdata // Read data, valid with memAck
);
    import aci_pkg::*;
    logic [WORD_W-1:0] mem [0:7];
    logic [3:0] waitCnt;
    // -----------------------------------------------------------------
    // Storage contents
    // -----------------------------------------------------------------
    initial begin
        mem = '{default: 48'h0};
        mem[0] = INIT0;
        mem[7] = INIT7;
    end
    // Core reference: old word read out, new word written, one ack per request
    always @(posedge sys_clk) begin
        if (!nrst) begin
            memAck <= 1'b0;
            waitCnt <= 4'h0;
        end else if (memAck) begin
            memAck <= 1'b0;
            memRdata <= ~memRdata; // Data not valid outside ack never repeats a word
            waitCnt <= 4'h0;
        end else if (memReq.req) begin
            if (waitCnt >= (slow ? 4'h5 : 4'h0)) begin
                memAck <= 1'b1;
                memRdata <= mem[memReq.addr[2:0]];
                if (memReq.we) begin
                    mem[memReq.addr[2:0]] <= memReq.wdata;
                end
            end else begin
                waitCnt <= waitCnt + 4'h1;
            end
        end
    end
endmodule : aci_mem_model
`default_nettype wire

/* bench/aci_aux_service_tb.sv */
`timescale 1ns/10ps
`default_nettype none
module aci_aux_service_tb;
    import aci_pkg::*;
    typedef struct packed {
        logic [NSRC-1:0] cable;
        logic [NCOND-1:0] cond;
        logic [3:0] idx;
        logic en;
        logic any;
    } aci_row_t;
    logic sys_clk = 1'b0, nrst = 1'b0, mainsTick = 1'b0, seqExit = 1'b0, stDone = 1'b0;
    logic cpuStopped = 1'b0, svcDone = 1'b0, halfFlagIn = 1'b1, slow = 1'b0, memAck;
    logic accLoad_r, pcLoad_r, irLoad_r, halfExit_r, auxBusy_r, clockEnable_r;
    logic tickPending_r, intrBlock_r, savedHalf_r;
    aci_fsel_t fsel = '0;
    logic [NSRC-1:0] cableIntr = '0;
    logic [NCOND-1:0] condRaw = '0;
    logic [WORD_W-1:0] memRdata, accIn = 48'h0123_4567_89ab, accOut_r;
    logic [PC_W-1:0] pcIn = 15'h1234, pcOut_r;
    logic [LOWER_INSTR_W-1:0] irOut_r;
    logic [2:0] scanPos_r, held;
    aci_mem_req_t memReq_r;
    int n_mismatch = 0, n_compared = 0, nEntry = 0, k;
    // Rows: cable lines, conditions, condition to select (if en), combined line expected
    aci_row_t rows [7] = '{'{4'h0, 16'h0000, 4'h0, 1'b0, 1'b0},
        '{4'h1, 16'h0000, 4'h0, 1'b0, 1'b1}, '{4'h8, 16'h0000, 4'h0, 1'b0, 1'b1},
        '{4'h0, 16'h0010, 4'h0, 1'b0, 1'b0}, '{4'h0, 16'h0010, 4'h4, 1'b1, 1'b1},
        '{4'h0, 16'h8000, 4'he, 1'b1, 1'b0}, '{4'h0, 16'h4000, 4'h0, 1'b0, 1'b1}};

    always #50 sys_clk = ~sys_clk;
    aci_aux_service aci_aux_service_inst (.sys_clk(sys_clk), .nrst(nrst),
        .mainsTick(mainsTick), .fsel(fsel), .cableIntr(cableIntr), .condRaw(condRaw),
        .seqExit(seqExit), .stDone(stDone), .cpuStopped(cpuStopped), .svcDone(svcDone),
        .memAck(memAck), .memRdata(memRdata), .accIn(accIn), .pcIn(pcIn),
        .halfFlagIn(halfFlagIn), .memReq_r(memReq_r), .accOut_r(accOut_r),
        .accLoad_r(accLoad_r), .pcOut_r(pcOut_r), .pcLoad_r(pcLoad_r), .irOut_r(irOut_r),
        .irLoad_r(irLoad_r), .halfExit_r(halfExit_r), .auxBusy_r(auxBusy_r),
        .clockEnable_r(clockEnable_r), .tickPending_r(tickPending_r),
        .intrBlock_r(intrBlock_r), .savedHalf_r(savedHalf_r), .scanPos_r(scanPos_r));
    aci_mem_model aci_mem_model_inst (.sys_clk(sys_clk), .nrst(nrst), .memReq(memReq_r),
        .slow(slow), .memAck(memAck), .memRdata(memRdata));

    // Count interrupt entries; a blocked or refused one must never add here
    always @(negedge sys_clk) begin
        if (irLoad_r === 1'b1) begin
            nEntry++;
        end
    end
    // -----------------------------------------------------------------
    // Helpers
    // -----------------------------------------------------------------
    task automatic chk(input logic [47:0] got, input logic [47:0] exp);
        n_compared++;
        if (got !== exp) begin
            $display("Error t=%0t got=%h exp=%h", $time, got, exp);
            n_mismatch++;
        end
    endtask : chk
    // One-cycle function-select strobe
    task automatic fs(input logic setC, input logic clrC, input logic [3:0] c,
        input logic en, input logic dis);
        @(negedge sys_clk);
        fsel <= '{sel: 1'b1, setClk: setC, clrClk: clrC, cond: c, enIntr: en, disIntr: dis};
        @(negedge sys_clk);
        fsel <= '0;
    endtask : fs
    task automatic tally_and_finish();
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : tally_and_finish

    // Watchdog: the whole sequence needs well under a thousand cycles
    initial begin
        repeat (4000) @(posedge sys_clk);
        n_mismatch++;
        tally_and_finish();
    end
    // -----------------------------------------------------------------
    // Main sequence
    // -----------------------------------------------------------------
    initial begin
        repeat (20) @(negedge sys_clk);
        chk({memReq_r.req, auxBusy_r, clockEnable_r, tickPending_r, intrBlock_r, scanPos_r}, 0);
        nrst <= 1'b1;
        // Source combining through the top: with no start opening the scanner
        // parks at the interrupt position exactly while the combined line is up
        foreach (rows[i]) begin
            fs(1'b0, 1'b0, rows[i].idx, rows[i].en, 1'b0);
            {cableIntr, condRaw} <= {rows[i].cable, rows[i].cond};
            repeat (9) @(negedge sys_clk);
            held = scanPos_r;
            @(negedge sys_clk);
            chk(held == scanPos_r && held == SCAN_INTR_POS, rows[i].any);
        end
        {cableIntr, condRaw, seqExit} <= {4'h0, 16'h0000, 1'b1};
        // Clock advance with slow storage and accumulator changing mid-way
        slow <= 1'b1;
        fs(1'b1, 1'b0, 4'h0, 1'b0, 1'b0);
        chk(clockEnable_r, 1'b1);
        mainsTick <= 1'b1;
        @(negedge sys_clk);
        mainsTick <= 1'b0;
        for (k = 0; k < 50 && auxBusy_r !== 1'b1; k++) @(negedge sys_clk);
        chk(auxBusy_r, 1'b1);
        chk(scanPos_r, SCAN_CLOCK_POS);
        accIn <= 48'hffff_0000_ffff;
        for (k = 0; k < 50 && accLoad_r !== 1'b1; k++) @(negedge sys_clk);
        chk(accLoad_r, 1'b1);
        chk(accOut_r, 48'h0123_4567_89ab);
        chk(aci_mem_model_inst.mem[0], 48'h0000_0100_0000);
        chk(tickPending_r, 1'b0);
        // Disabled clock: a mains tick must not advance
        fs(1'b0, 1'b1, 4'h0, 1'b0, 1'b0);
        mainsTick <= 1'b1;
        @(negedge sys_clk);
        mainsTick <= 1'b0;
        repeat (20) @(negedge sys_clk);
        chk({tickPending_r, clockEnable_r}, 2'b00);
        chk(aci_mem_model_inst.mem[0], 48'h0000_0100_0000);
        // Interrupt entry from a cable line, prompt storage, opened by an ST completion
        {slow, seqExit, stDone} <= 3'b001;
        cableIntr <= 4'h4;
        for (k = 0; k < 60 && irLoad_r !== 1'b1; k++) @(negedge sys_clk);
        chk({pcLoad_r, pcOut_r, irOut_r}, {1'b1, INTR_ADDR, 24'h5abcde});
        chk({intrBlock_r, savedHalf_r}, 2'b10);
        chk(aci_mem_model_inst.mem[7][38:24], 15'h1234);
        @(negedge sys_clk);
        chk(halfExit_r, 1'b1);
        repeat (40) @(negedge sys_clk);
        chk(nEntry, 1);
        svcDone <= 1'b1;
        cableIntr <= 4'h0;
        @(negedge sys_clk);
        svcDone <= 1'b0;
        @(negedge sys_clk);
        chk(intrBlock_r, 1'b0);
        // Selected internal condition, no start window until the computer stops
        {seqExit, stDone, slow, halfFlagIn} <= 4'b0010;
        fs(1'b0, 1'b0, 4'h3, 1'b1, 1'b0);
        condRaw <= 16'h0008;
        repeat (30) @(negedge sys_clk);
        chk(nEntry, 1);
        cpuStopped <= 1'b1;
        for (k = 0; k < 80 && irLoad_r !== 1'b1; k++) @(negedge sys_clk);
        chk({irLoad_r, savedHalf_r, intrBlock_r}, 3'b111);
        // Deselect the condition; it stays present but must stay silent
        fs(1'b0, 1'b0, 4'h3, 1'b0, 1'b1);
        svcDone <= 1'b1;
        @(negedge sys_clk);
        svcDone <= 1'b0;
        repeat (30) @(negedge sys_clk);
        chk(nEntry, 2);
        tally_and_finish();
    end
endmodule : aci_aux_service_tb
`default_nettype wire
